// ===== src/rsu_map.vh
// Field layout, reset values and timing constants of the upgrade register set.
// Assumes inclusion by bare name from the design files under src/.
`ifndef RSU_MAP_VH
`define RSU_MAP_VH

// Upgrade control / update register layout
`define RSU_CTL_W 38
`define RSU_CTL_APP 0
`define RSU_CTL_PAGE_LO 1
`define RSU_CTL_PAGE_HI 24
`define RSU_CTL_WDEN 25
`define RSU_CTL_TMO_LO 26
`define RSU_CTL_TMO_HI 37
`define RSU_CTL_RST 38'h00_0000_0000

// Reconfiguration cause register layout
`define RSU_STS_W 5
`define RSU_STS_CRC 0
`define RSU_STS_STATUS_PIN 1
`define RSU_STS_FABRIC 2
`define RSU_STS_CONFIG_PIN 3
`define RSU_STS_WDOG 4
`define RSU_STS_RST 5'h00

// Shift register: cause bits above the control/update image
`define RSU_SHIFT_W 43

// Watchdog count: timeout field on top of a zero low part
`define RSU_WD_W 29
`define RSU_WD_LOW_W 17
`define RSU_WD_LOW 17'h0_0000

// Timing: core clock and least strobe length
`define RSU_CLK_MHZ 200
`define RSU_STROBE_MIN_NS 250
`define RSU_STROBE_CYC ((`RSU_STROBE_MIN_NS * `RSU_CLK_MHZ + 999) / 1000)

`endif

// ===== src/rsu_sync.v
// Two-stage synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level relative to the clock.
`timescale 1ns/1ps
module rsu_sync #(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Data
	input wire [WIDTH-1:0] d,
	output wire [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end else begin
			meta_r <= d;
			sync_r <= meta_r;
		end
	end

	assign q = sync_r;
endmodule // rsu_sync

// ===== src/rsu_regs.v
// Remote upgrade register set: shift, update, control and cause registers,
// user watchdog and the reconfiguration trigger logic.
// Assumes core_clk stands in for the internal oscillator; all fabric and pin
// inputs are asynchronous and pass the synchroniser; crc_error and
// config_done come from the configuration engine on core_clk.
//
// Functional notes
// - Fabric reaches update, cause and control registers through a serial shift register.
// - Capture while an application runs copies the control register into the shift.
// - A fabric reconfiguration request moves the update register into control.
// - Update register changes only under factory image, by shift then update.
// - Capture under factory image loads update register into the shift register.
// - Every reconfiguration writes the cause register with its trigger.
// - Capture copies the cause register into the shift register.
// - Control and cause on the oscillator clock; shift and update step on sampled upgrade clock rises.
// - Power-up clears the page address so the factory page zero loads.
// - Factory image may write the control register.
// - Control: flag bit 0, page 24..1, watchdog enable 25, timeout 37..26.
// - Error fall-back to factory clears the application flag.
// - Flag set: control register is read only.
// - Flag clear: control writable and user watchdog disabled.
// - All control fields default to zero.
// - Watchdog count is timeout field followed by seventeen zero bits.
// - Device never changes the flag itself apart from fall-back; fabric may set it.
// - Cause register: CRC, status pin, fabric, config pin, watchdog bits.
// - Power-on reset clears every cause bit.
// - Fabric reconfiguration loads the page held in the update register.
// - Pin, CRC or watchdog causes clear control; fabric cause loads update.
// - Watchdog expiry sets the watchdog cause and reloads the factory image.
// - Watchdog runs only for an application image in user mode.
`timescale 1ns/1ps
`include "rsu_map.vh"
module rsu_regs #(
	parameter STROBE_CYC = `RSU_STROBE_CYC
) (
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// Serial access from the fabric
	input wire upgrade_user_clock,
	input wire shift_not_load,
	input wire capture_not_update,
	input wire upgrade_serial_in,
	output wire upgrade_serial_out,
	// Fabric strobes, active low
	input wire fabric_reconfig_request_n,
	input wire watchdog_restart_n,
	// Device pins, active low
	input wire config_reset_pin_n,
	input wire status_error_pin_n,
	// Configuration engine
	input wire crc_error,
	input wire config_done,
	output wire config_start,
	output reg [23:0] page_start_address,
	output wire user_mode,
	output wire app_image,
	output wire watchdog_running
);
	localparam ST_CONFIG = 1'b0;
	localparam ST_USER = 1'b1;
	localparam CNT_W = 16;
	localparam [CNT_W-1:0] STROBE_MAX = STROBE_CYC[CNT_W-1:0];

	// Saturating count of cycles a strobe has been low
	function [CNT_W-1:0] low_count;
		input strobe_n;
		input [CNT_W-1:0] cnt;
		begin
			if (strobe_n)
				low_count = {CNT_W{1'b0}};
			else if (cnt == STROBE_MAX)
				low_count = cnt;
			else
				low_count = cnt + 16'h0001;
		end
	endfunction

	// Watchdog reload value from a control image
	function [`RSU_WD_W-1:0] wd_load;
		input [`RSU_CTL_W-1:0] ctl;
		begin
			wd_load = {ctl[`RSU_CTL_TMO_HI:`RSU_CTL_TMO_LO], `RSU_WD_LOW};
		end
	endfunction

	// Synchronised inputs
	wire [7:0] sync_q;
	wire ruclk_s;
	wire shift_s;
	wire capt_s;
	wire din_s;
	wire req_n_s;
	wire wdrst_n_s;
	wire cfgpin_n_s;
	wire stspin_n_s;

	// Active-low strobes and pins idle high through reset
	rsu_sync #(
		.WIDTH(8),
		.RST_VAL(8'hf0)
	) u_sync (
		.clk(core_clk),
		.nrst(nrst),
		.d({status_error_pin_n, config_reset_pin_n, watchdog_restart_n,
			fabric_reconfig_request_n, upgrade_serial_in, capture_not_update,
			shift_not_load, upgrade_user_clock}),
		.q(sync_q)
	);

	assign ruclk_s = sync_q[0];
	assign shift_s = sync_q[1];
	assign capt_s = sync_q[2];
	assign din_s = sync_q[3];
	assign req_n_s = sync_q[4];
	assign wdrst_n_s = sync_q[5];
	assign cfgpin_n_s = sync_q[6];
	assign stspin_n_s = sync_q[7];

	// Registers
	reg ruclk_prev_r;
	reg [`RSU_SHIFT_W-1:0] shift_r;
	reg [`RSU_SHIFT_W-1:0] shift_nxt;
	reg [`RSU_CTL_W-1:0] update_r;
	reg [`RSU_CTL_W-1:0] update_nxt;
	reg [`RSU_CTL_W-1:0] control_r;
	reg [`RSU_CTL_W-1:0] control_nxt;
	reg [`RSU_STS_W-1:0] cause_r;
	reg [`RSU_STS_W-1:0] cause_nxt;
	reg state_r;
	reg state_nxt;
	reg [`RSU_WD_W-1:0] wd_cnt_r;
	reg [`RSU_WD_W-1:0] wd_cnt_nxt;
	reg [CNT_W-1:0] req_cnt_r;
	reg [CNT_W-1:0] wdrst_cnt_r;
	reg req_fired_r;
	reg wdrst_fired_r;
	reg cfgpin_prev_r;
	reg stspin_prev_r;
	reg start_r;
	reg start_nxt;

	wire ruclk_rise;
	wire factory;
	wire wd_on;
	wire wd_expire;
	wire req_hit;
	wire wdrst_hit;
	wire cfgpin_hit;
	wire stspin_hit;
	wire any_error;
	wire any_trigger;

	// Upgrade clock edges found by sampling; shift and update follow them
	assign ruclk_rise = ruclk_s & ~ruclk_prev_r;
	assign factory = ~control_r[`RSU_CTL_APP];
	// Watchdog only for an enabled application in user mode
	assign wd_on = ~factory & control_r[`RSU_CTL_WDEN] & (state_r == ST_USER);
	assign wd_expire = wd_on & (wd_cnt_r == {`RSU_WD_W{1'b0}});

	// Strobes act once, after being held low for the least time
	assign req_hit = (req_cnt_r == STROBE_MAX) & ~req_fired_r;
	assign wdrst_hit = (wdrst_cnt_r == STROBE_MAX) & ~wdrst_fired_r;
	assign cfgpin_hit = cfgpin_prev_r & ~cfgpin_n_s;
	assign stspin_hit = stspin_prev_r & ~stspin_n_s;
	assign any_error = cfgpin_hit | stspin_hit | crc_error | wd_expire;
	assign any_trigger = any_error | req_hit;

	// Serial access
	always @* begin
		shift_nxt = shift_r;
		update_nxt = update_r;
		if (ruclk_rise) begin
			if (shift_s) begin
				shift_nxt = {din_s, shift_r[`RSU_SHIFT_W-1:1]};
			end else if (capt_s) begin
				// Capture: cause bits on top, then update or control image
				if (factory)
					shift_nxt = {cause_r, update_r};
				else
					shift_nxt = {cause_r, control_r};
			end else if (factory) begin
				// Update is ignored while an application runs
				update_nxt = shift_r[`RSU_CTL_W-1:0];
			end
		end
	end

	// Reconfiguration, control and cause
	always @* begin
		state_nxt = state_r;
		control_nxt = control_r;
		cause_nxt = cause_r;
		start_nxt = 1'b0;
		if (any_trigger) begin
			state_nxt = ST_CONFIG;
			start_nxt = 1'b1;
			// Pins first, then CRC, watchdog, fabric request
			cause_nxt = `RSU_STS_RST;
			if (cfgpin_hit)
				cause_nxt[`RSU_STS_CONFIG_PIN] = 1'b1;
			else if (stspin_hit)
				cause_nxt[`RSU_STS_STATUS_PIN] = 1'b1;
			else if (crc_error)
				cause_nxt[`RSU_STS_CRC] = 1'b1;
			else if (wd_expire)
				cause_nxt[`RSU_STS_WDOG] = 1'b1;
			else
				cause_nxt[`RSU_STS_FABRIC] = 1'b1;
			if (any_error)
				control_nxt = `RSU_CTL_RST;
			else
				control_nxt = update_r;
		end else begin
			case (state_r)
				ST_CONFIG: begin
					if (config_done)
						state_nxt = ST_USER;
				end
				ST_USER: begin
					state_nxt = ST_USER;
				end
				default: begin
					state_nxt = ST_CONFIG;
				end
			endcase
		end
	end

	// Watchdog countdown
	always @* begin
		wd_cnt_nxt = wd_cnt_r;
		if (!wd_on || wdrst_hit)
			wd_cnt_nxt = wd_load(control_r);
		else if (wd_cnt_r != {`RSU_WD_W{1'b0}})
			wd_cnt_nxt = wd_cnt_r - 29'h0000_0001;
	end

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ruclk_prev_r <= 1'b0;
			shift_r <= {`RSU_SHIFT_W{1'b0}};
			update_r <= `RSU_CTL_RST;
			control_r <= `RSU_CTL_RST;
			cause_r <= `RSU_STS_RST;
			state_r <= ST_CONFIG;
			wd_cnt_r <= {`RSU_WD_W{1'b0}};
			req_cnt_r <= {CNT_W{1'b0}};
			wdrst_cnt_r <= {CNT_W{1'b0}};
			req_fired_r <= 1'b0;
			wdrst_fired_r <= 1'b0;
			cfgpin_prev_r <= 1'b1;
			stspin_prev_r <= 1'b1;
			start_r <= 1'b0;
			page_start_address <= 24'h00_0000;
		end else begin
			ruclk_prev_r <= ruclk_s;
			shift_r <= shift_nxt;
			update_r <= update_nxt;
			control_r <= control_nxt;
			cause_r <= cause_nxt;
			state_r <= state_nxt;
			wd_cnt_r <= wd_cnt_nxt;
			req_cnt_r <= low_count(req_n_s, req_cnt_r);
			wdrst_cnt_r <= low_count(wdrst_n_s, wdrst_cnt_r);
			// One action per low strobe, rearmed on release
			req_fired_r <= ~req_n_s & (req_fired_r | req_hit);
			wdrst_fired_r <= ~wdrst_n_s & (wdrst_fired_r | wdrst_hit);
			cfgpin_prev_r <= cfgpin_n_s;
			stspin_prev_r <= stspin_n_s;
			start_r <= start_nxt;
			page_start_address <= control_nxt[`RSU_CTL_PAGE_HI:`RSU_CTL_PAGE_LO];
		end
	end

	assign upgrade_serial_out = shift_r[0];
	assign config_start = start_r;
	assign user_mode = (state_r == ST_USER);
	assign app_image = control_r[`RSU_CTL_APP];
	assign watchdog_running = wd_on;
endmodule // rsu_regs

// ===== verif/rsu_regs_properties.sv
// Checker for the upgrade register set, bound to its top module.
// Assumes one domain on core_clk with async active-low nrst.
`timescale 1ns/1ps
module rsu_regs_properties (
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// Watched ports
	input wire crc_error,
	input wire config_done,
	input wire config_start,
	input wire [23:0] page_start_address,
	input wire user_mode,
	input wire app_image,
	input wire watchdog_running
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_entry;
		config_done && !user_mode;
	endsequence
	sequence s_crc_hit;
		crc_error ##1 config_start;
	endsequence
	a_start_pulse: assert property (config_start |=> !config_start)
		else $error("config_start longer than one cycle");
	a_start_exit: assert property (config_start |-> !user_mode)
		else $error("user mode kept across reconfiguration");
	a_wd_gated: assert property (watchdog_running |-> user_mode && app_image)
		else $error("watchdog running outside application user mode");
	a_crc_trigger: assert property (crc_error |=> config_start)
		else $error("crc error gave no reconfiguration");
	a_crc_clear: assert property (s_crc_hit |-> !app_image && page_start_address == 24'h0)
		else $error("control not cleared after crc error");
	a_user_entry: assert property (s_entry |=> user_mode || config_start)
		else $error("user mode not entered after config_done");
	a_page_hold: assert property (!config_start |-> $stable(page_start_address))
		else $error("page changed without reconfiguration");
	a_flag_hold: assert property (!config_start |-> $stable(app_image))
		else $error("flag changed without reconfiguration");
endmodule // rsu_regs_properties

bind rsu_regs rsu_regs_properties rsu_regs_properties_i (
	.core_clk(core_clk), .nrst(nrst), .crc_error(crc_error), .config_done(config_done),
	.config_start(config_start), .page_start_address(page_start_address),
	.user_mode(user_mode), .app_image(app_image), .watchdog_running(watchdog_running));

// ===== verif/rsu_fabric_model.sv
// Fabric side of the serial upgrade link: frames, capture and update.
// Assumes core_clk from the bench; upgrade clock idles low between frames.
`timescale 1ns/1ps
module rsu_fabric_model (
	// Clock
	input wire core_clk,
	// Serial link
	input wire upgrade_serial_out,
	output reg upgrade_user_clock,
	output reg shift_not_load,
	output reg capture_not_update,
	output reg upgrade_serial_in
);
	initial begin
		upgrade_user_clock = 1'b0;
		shift_not_load = 1'b0;
		capture_not_update = 1'b1;
		upgrade_serial_in = 1'b0;
	end
	// One 125 ns period, data set well before the rise
	task tick;
		begin
			repeat (13) @(negedge core_clk);
			upgrade_user_clock = 1'b1;
			repeat (12) @(negedge core_clk);
			upgrade_user_clock = 1'b0;
		end
	endtask
	task op(input cap);
		begin
			shift_not_load = 1'b0;
			capture_not_update = cap;
			tick;
		end
	endtask
	task frame(input [42:0] din, output [42:0] dout);
		integer i;
		begin
			for (i = 0; i < 43; i = i + 1) begin
				dout[i] = upgrade_serial_out;
				upgrade_serial_in = din[i];
				shift_not_load = 1'b1;
				tick;
			end
			// Released line must not keep the last bit
			upgrade_serial_in = ~din[42];
		end
	endtask
endmodule // rsu_fabric_model

// ===== verif/rsu_regs_tb.sv
// Self-checking bench for the upgrade register set.
// Assumes the fabric model drives the serial link; the bench drives strobes and pins.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count = check_count + 1; if ((a) !== (b)) begin \
	n_fail = n_fail + 1; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module rsu_regs_tb;
	localparam [37:0] IMG_A = {12'h000, 1'b0, 24'h5a3c96, 1'b1};
	localparam [37:0] IMG_W = {12'h000, 1'b1, 24'h000abc, 1'b1};
	reg core_clk, nrst, config_done, crc_error, fabric_reconfig_request_n;
	reg watchdog_restart_n, config_reset_pin_n, status_error_pin_n, hit;
	wire upgrade_user_clock, shift_not_load, capture_not_update, upgrade_serial_in;
	wire upgrade_serial_out, config_start, user_mode, app_image, watchdog_running;
	wire [23:0] page_start_address;
	reg [42:0] rd;
	integer n_fail, check_count, cyc, k;
	rsu_regs #(.STROBE_CYC(4)) rsu_regs_i (.core_clk(core_clk), .nrst(nrst),
		.upgrade_user_clock(upgrade_user_clock), .shift_not_load(shift_not_load),
		.capture_not_update(capture_not_update), .upgrade_serial_in(upgrade_serial_in),
		.upgrade_serial_out(upgrade_serial_out), .watchdog_restart_n(watchdog_restart_n),
		.fabric_reconfig_request_n(fabric_reconfig_request_n),
		.config_reset_pin_n(config_reset_pin_n), .status_error_pin_n(status_error_pin_n),
		.crc_error(crc_error), .config_done(config_done), .config_start(config_start),
		.page_start_address(page_start_address), .user_mode(user_mode),
		.app_image(app_image), .watchdog_running(watchdog_running));
	rsu_fabric_model rsu_fabric_model_i (.core_clk(core_clk),
		.upgrade_serial_out(upgrade_serial_out), .upgrade_user_clock(upgrade_user_clock),
		.shift_not_load(shift_not_load), .capture_not_update(capture_not_update),
		.upgrade_serial_in(upgrade_serial_in));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			n_fail = n_fail + 1;
			complete_run;
		end
	end
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", check_count, n_fail);
			if (n_fail == 0 && check_count > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// Looks before waiting: a one-cycle start may already stand
	task wait_start;
		begin
			hit = 1'b0;
			repeat (200) if (!hit) begin
				if (config_start === 1'b1)
					hit = 1'b1;
				else
					@(negedge core_clk);
			end
		end
	endtask
	task rd_regs;
		begin
			rsu_fabric_model_i.op(1'b1);
			rsu_fabric_model_i.frame(43'h0, rd);
		end
	endtask
	task wr_regs(input [42:0] v);
		begin
			rsu_fabric_model_i.frame(v, rd);
			rsu_fabric_model_i.op(1'b0);
		end
	endtask
	// Request held the full 250 ns, released once
	task req_fab;
		begin
			fabric_reconfig_request_n = 1'b0;
			wait_start;
			repeat (50) @(negedge core_clk);
			fabric_reconfig_request_n = 1'b1;
			`CHK(hit, 1'b1)
		end
	endtask
	task t_reset;
		begin
			`CHK({app_image, watchdog_running, user_mode}, 3'b000)
			`CHK(page_start_address, 24'h0)
			rd_regs;
			`CHK(rd, 43'h0)
			$display("reset test done");
		end
	endtask
	task t_load_app;
		begin
			wr_regs({5'h1f, IMG_A});
			rd_regs;
			`CHK(rd, {5'h00, IMG_A})
			req_fab;
			`CHK(page_start_address, 24'h5a3c96)
			`CHK(app_image, 1'b1)
			rd_regs;
			`CHK(rd, {5'h04, IMG_A})
			$display("load test done");
		end
	endtask
	task t_refused;
		begin
			wr_regs({5'h00, 38'h3f_ffff_fffe});
			rd_regs;
			`CHK(rd, {5'h04, IMG_A})
			req_fab;
			`CHK(page_start_address, 24'h5a3c96)
			$display("refused update test done");
		end
	endtask
	task t_watchdog;
		begin
			crc_error = 1'b1;
			@(negedge core_clk);
			crc_error = 1'b0;
			wait_start;
			`CHK(hit, 1'b1)
			`CHK(app_image, 1'b0)
			wr_regs({5'h00, IMG_W});
			req_fab;
			`CHK(watchdog_running, 1'b0)
			config_done = 1'b1;
			@(negedge core_clk);
			config_done = 1'b0;
			`CHK({user_mode, watchdog_running}, 2'b11)
			wait_start;
			`CHK(hit, 1'b1)
			`CHK({app_image, page_start_address}, 25'h0)
			rd_regs;
			`CHK(rd[42:38], 5'h10)
			$display("watchdog test done");
		end
	endtask
	task t_pins;
		begin
			for (k = 0; k < 3; k = k + 1) begin
				req_fab;
				`CHK(app_image, 1'b1)
				config_reset_pin_n = (k != 0);
				status_error_pin_n = (k != 1);
				crc_error = (k == 2);
				@(negedge core_clk);
				crc_error = 1'b0;
				wait_start;
				config_reset_pin_n = 1'b1;
				status_error_pin_n = 1'b1;
				`CHK({hit, app_image, page_start_address}, 26'h200_0000)
				rd_regs;
				`CHK(rd[42:38], (k == 0) ? 5'h08 : (k == 1) ? 5'h02 : 5'h01)
			end
			$display("pin and crc test done");
		end
	endtask
	initial begin
		n_fail = 0;
		check_count = 0;
		cyc = 0;
		nrst = 1'b0;
		config_done = 1'b0;
		crc_error = 1'b0;
		fabric_reconfig_request_n = 1'b1;
		watchdog_restart_n = 1'b1;
		config_reset_pin_n = 1'b1;
		status_error_pin_n = 1'b1;
		repeat (2) @(negedge core_clk);
		nrst = 1'b1;
		repeat (3) @(negedge core_clk);
		t_reset;
		t_load_app;
		t_refused;
		t_watchdog;
		t_pins;
		complete_run;
	end
endmodule // rsu_regs_tb
